// ### inc/sipr_pkg.sv
`default_nettype none
package sipr_pkg;
	// ----------------------------------------
	// register map, byte addresses
	// ----------------------------------------
	localparam logic [7:0] SIPR_OFF_CODE_SEL = 8'h00;
	localparam logic [7:0] SIPR_OFF_STACK_SEL = 8'h04;
	localparam logic [7:0] SIPR_OFF_DATA_PRI = 8'h08;
	localparam logic [7:0] SIPR_OFF_DATA_EXT = 8'h0C;
	localparam logic [7:0] SIPR_OFF_DATA_THIRD = 8'h10;
	localparam logic [7:0] SIPR_OFF_DATA_FOURTH = 8'h14;
	localparam logic [7:0] SIPR_OFF_NEXT_IOFS = 8'h18;
	localparam logic [7:0] SIPR_OFF_FRAME_PTR = 8'h1C;
	localparam logic [7:0] SIPR_OFF_SHORT_IOFS = 8'h20;
	localparam logic [7:0] SIPR_OFF_MODE = 8'h24;
	localparam logic [7:0] SIPR_OFF_LIMIT = 8'h28;
	localparam logic [7:0] SIPR_OFF_CODE_ADDR = 8'h2C;
	localparam logic [7:0] SIPR_OFF_STACK_ADDR = 8'h30;
	localparam logic [7:0] SIPR_OFF_CODE_BASE = 8'h34;
	localparam logic [7:0] SIPR_OFF_STACK_BASE = 8'h38;
	// ----------------------------------------
	// sizes and codes
	// ----------------------------------------
	localparam int SIPR_NUM_SEL = 6;
	localparam int SIPR_SEL_W = 16;
	localparam logic [31:0] SIPR_REAL_LIMIT = 32'h0000_FFFF;
	localparam logic [31:0] SIPR_PROT_LIMIT_MAX = 32'hFFFF_FFFF;
	localparam logic [1:0] SIPR_RESP_OKAY = 2'h0;
	localparam logic [1:0] SIPR_RESP_SLVERR = 2'h2;
	localparam logic [2:0] SIPR_SEL_CODE = 3'h0;
	localparam logic [2:0] SIPR_SEL_STACK = 3'h1;
	localparam logic [2:0] SIPR_SEL_PRI = 3'h2;
	localparam logic [2:0] SIPR_SEL_EXT = 3'h3;
	localparam logic [2:0] SIPR_SEL_THIRD = 3'h4;
	localparam logic [2:0] SIPR_SEL_FOURTH = 3'h5;
	// core-side write port
	typedef struct packed {
		logic sel_we;
		logic [2:0] sel_idx;
		logic [15:0] sel_data;
		logic iofs_we;
		logic iofs_short;
		logic [31:0] iofs_data;
		logic fptr_we;
		logic [31:0] fptr_data;
	} sipr_core_wr_t;
	// segment size view
	typedef struct packed {
		logic prot_mode;
		logic [31:0] limit;
	} sipr_limit_t;
endpackage
`default_nettype wire

// ### core/sipr_merge.sv
`default_nettype none
// ----------------------------------------
// byte-lane merge for a bus write
// ----------------------------------------
module sipr_merge
(
	// data
	input wire logic [31:0] old_in,
	input wire logic [31:0] new_in,
	input wire logic [3:0] strb_in,
	output logic [31:0] merged_out
);
	genvar gi;
	// each lane keeps its old byte unless strobed
	generate
		for (gi = 0; gi < 4; gi = gi + 1)
		begin : g_lane
			assign merged_out[gi*8 +: 8] = strb_in[gi] ? new_in[gi*8 +: 8] : old_in[gi*8 +: 8];
		end
	endgenerate
endmodule // sipr_merge
`default_nettype wire

// ### core/sipr_limit.sv
`default_nettype none
// ----------------------------------------
// segment size limit by address mode
// ----------------------------------------
module sipr_limit
	import sipr_pkg::*;
(
	// mode and protected limit
	input wire logic prot_mode_in,
	input wire logic [31:0] prot_limit_in,
	// result
	output sipr_pkg::sipr_limit_t lim_out
);
	// real mode ignores the programmed limit entirely
	assign lim_out.prot_mode = prot_mode_in;
	assign lim_out.limit = prot_mode_in ? prot_limit_in : SIPR_REAL_LIMIT;
endmodule // sipr_limit
`default_nettype wire

// ### core/sipr_top.sv
`default_nettype none
module sipr_top
	import sipr_pkg::*;
(
	// clock and reset
	input wire logic clk_in,
	input wire logic resetn_in,
	// core execution write port
	input wire sipr_pkg::sipr_core_wr_t core_wr_in,
	// segment bases from the descriptor logic
	input wire logic [31:0] code_base_in,
	input wire logic [31:0] stack_base_in,
	// register views for the core
	output logic [SIPR_NUM_SEL*SIPR_SEL_W-1:0] selectors_out,
	output logic [31:0] next_instruction_offset_out,
	output logic [15:0] short_instruction_offset_out,
	output logic [31:0] stack_frame_pointer_out,
	output logic [31:0] fetch_addr_out,
	output logic [31:0] frame_addr_out,
	output sipr_pkg::sipr_limit_t seg_limit_out,
	output logic iofs_over_limit_out,
	// axi4-lite write address
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import sipr_pkg::*;

	// ----------------------------------------
	// architectural storage
	// ----------------------------------------
	// no reset on the data: contents after reset are undefined
	logic [SIPR_SEL_W-1:0] sel_reg [SIPR_NUM_SEL];
	logic [31:0] iofs_reg;
	logic [31:0] fptr_reg;
	// mode and protected limit are control state, reset defined
	logic prot_mode_reg;
	logic [31:0] prot_limit_reg;

	// ----------------------------------------
	// bus slave state
	// ----------------------------------------
	logic aw_held_reg;
	logic [7:0] aw_addr_reg;
	logic w_held_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic bvalid_reg;
	logic [1:0] bresp_reg;
	logic rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0] rresp_reg;

	// ----------------------------------------
	// write path decode
	// ----------------------------------------
	// the write fires once both halves are held and no response is pending
	wire bus_wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
	wire [31:0] wr_old;
	wire [31:0] wr_merged;
	wire wr_is_sel = (aw_addr_reg <= SIPR_OFF_DATA_FOURTH) && (aw_addr_reg[1:0] == 2'b00);
	wire [2:0] wr_sel_idx = aw_addr_reg[4:2];
	wire wr_is_iofs = aw_addr_reg == SIPR_OFF_NEXT_IOFS;
	wire wr_is_fptr = aw_addr_reg == SIPR_OFF_FRAME_PTR;
	wire wr_is_short = aw_addr_reg == SIPR_OFF_SHORT_IOFS;
	wire wr_is_mode = aw_addr_reg == SIPR_OFF_MODE;
	wire wr_is_limit = aw_addr_reg == SIPR_OFF_LIMIT;
	wire wr_is_ro = (aw_addr_reg == SIPR_OFF_CODE_ADDR) || (aw_addr_reg == SIPR_OFF_STACK_ADDR)
		|| (aw_addr_reg == SIPR_OFF_CODE_BASE) || (aw_addr_reg == SIPR_OFF_STACK_BASE);
	wire wr_ok = wr_is_sel || wr_is_iofs || wr_is_fptr || wr_is_short || wr_is_mode
		|| wr_is_limit || wr_is_ro;
	// old value for the byte merge; read-only words take nothing
	assign wr_old = wr_is_sel ? {16'h0000, sel_reg[wr_sel_idx]} :
		wr_is_iofs ? iofs_reg :
		wr_is_fptr ? fptr_reg :
		wr_is_short ? {16'h0000, iofs_reg[15:0]} :
		wr_is_mode ? {31'h0000_0000, prot_mode_reg} :
		wr_is_limit ? prot_limit_reg : 32'h0000_0000;

	sipr_merge u_merge
	(
		.old_in(wr_old),
		.new_in(w_data_reg),
		.strb_in(w_strb_reg),
		.merged_out(wr_merged)
	);

	// ----------------------------------------
	// segment size limit
	// ----------------------------------------
	sipr_pkg::sipr_limit_t lim;
	sipr_limit u_limit
	(
		.prot_mode_in(prot_mode_reg),
		.prot_limit_in(prot_limit_reg),
		.lim_out(lim)
	);

	// ----------------------------------------
	// selector storage, one per generate entry
	// ----------------------------------------
	// the core port wins over the bus when both hit one register in a cycle
	genvar gs;
	generate
		for (gs = 0; gs < SIPR_NUM_SEL; gs = gs + 1)
		begin : g_sel
			wire core_hit = core_wr_in.sel_we && (core_wr_in.sel_idx == 3'(gs));
			wire bus_hit = bus_wr_fire && wr_is_sel && (wr_sel_idx == 3'(gs));
			always_ff @(posedge clk_in)
			begin
				if (core_hit)
					sel_reg[gs] <= core_wr_in.sel_data;
				else if (bus_hit)
					sel_reg[gs] <= wr_merged[15:0];
			end
			assign selectors_out[gs*SIPR_SEL_W +: SIPR_SEL_W] = sel_reg[gs];
		end
	endgenerate

	// ----------------------------------------
	// instruction offset and frame pointer
	// ----------------------------------------
	// a short write replaces bits 15:0 and leaves the upper half alone
	wire [31:0] core_iofs = core_wr_in.iofs_short ?
		{iofs_reg[31:16], core_wr_in.iofs_data[15:0]} : core_wr_in.iofs_data;
	wire [31:0] bus_iofs = wr_is_short ? {iofs_reg[31:16], wr_merged[15:0]} : wr_merged;
	wire bus_iofs_hit = bus_wr_fire && (wr_is_iofs || wr_is_short);
	wire bus_fptr_hit = bus_wr_fire && wr_is_fptr;

	// offset register: the core port wins over a bus write in the same cycle
	always_ff @(posedge clk_in)
	begin
		if (core_wr_in.iofs_we)
			iofs_reg <= core_iofs;
		else if (bus_iofs_hit)
			iofs_reg <= bus_iofs;
	end

	// frame pointer, same priority as the offset register
	always_ff @(posedge clk_in)
	begin
		if (core_wr_in.fptr_we)
			fptr_reg <= core_wr_in.fptr_data;
		else if (bus_fptr_hit)
			fptr_reg <= wr_merged;
	end

	// ----------------------------------------
	// mode control, reset to real mode
	// ----------------------------------------
	wire bus_mode_hit = bus_wr_fire && wr_is_mode;
	wire bus_limit_hit = bus_wr_fire && wr_is_limit;

	// mode bit: real mode out of reset
	always_ff @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
			prot_mode_reg <= 1'b0;
		else if (bus_mode_hit)
			prot_mode_reg <= wr_merged[0];
	end

	// protected limit: 64k out of reset keeps an early switch to protected mode harmless
	always_ff @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
			prot_limit_reg <= SIPR_REAL_LIMIT;
		else if (bus_limit_hit)
			prot_limit_reg <= wr_merged;
	end

	// ----------------------------------------
	// address formation
	// ----------------------------------------
	// offsets are relative to the segment base, never absolute
	assign next_instruction_offset_out = iofs_reg;
	assign short_instruction_offset_out = iofs_reg[15:0];
	assign stack_frame_pointer_out = fptr_reg;
	assign fetch_addr_out = code_base_in + iofs_reg;
	assign frame_addr_out = stack_base_in + fptr_reg;
	assign seg_limit_out = lim;
	// real mode checks only the 16-bit offset against 64k
	assign iofs_over_limit_out = lim.prot_mode ? (iofs_reg > lim.limit)
		: (32'(iofs_reg[15:0]) > lim.limit);

	// ----------------------------------------
	// write channel handshake
	// ----------------------------------------
	// address and data may arrive in either order; each is held until used
	assign s_axi_awready = !aw_held_reg;
	assign s_axi_wready = !w_held_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	// a slot takes its half only while empty, so a held half is never overwritten
	wire aw_take = s_axi_awvalid && !aw_held_reg;
	wire w_take = s_axi_wvalid && !w_held_reg;

	// write address slot: filled when offered, emptied when the write fires
	always_ff @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
			aw_held_reg <= 1'b0;
		else if (aw_take)
			aw_held_reg <= 1'b1;
		else if (bus_wr_fire)
			aw_held_reg <= 1'b0;
	end

	// write data slot, same scheme as the address slot
	always_ff @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
			w_held_reg <= 1'b0;
		else if (w_take)
			w_held_reg <= 1'b1;
		else if (bus_wr_fire)
			w_held_reg <= 1'b0;
	end

	// response: a firing write sets it and so wins over a clear in the same cycle
	always_ff @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			bvalid_reg <= 1'b0;
			bresp_reg <= SIPR_RESP_OKAY;
		end
		else if (bus_wr_fire)
		begin
			bvalid_reg <= 1'b1;
			bresp_reg <= wr_ok ? SIPR_RESP_OKAY : SIPR_RESP_SLVERR;
		end
		else if (s_axi_bready)
			bvalid_reg <= 1'b0;
	end

	// payload capture, no reset needed
	always_ff @(posedge clk_in)
	begin
		if (s_axi_awvalid && !aw_held_reg)
			aw_addr_reg <= s_axi_awaddr;
		if (s_axi_wvalid && !w_held_reg)
		begin
			w_data_reg <= s_axi_wdata;
			w_strb_reg <= s_axi_wstrb;
		end
	end

	// ----------------------------------------
	// read path decode
	// ----------------------------------------
	wire rd_is_sel = (s_axi_araddr <= SIPR_OFF_DATA_FOURTH) && (s_axi_araddr[1:0] == 2'b00);
	wire [2:0] rd_sel_idx = s_axi_araddr[4:2];
	wire rd_fire = s_axi_arvalid && !rvalid_reg;
	wire rd_is_iofs = s_axi_araddr == SIPR_OFF_NEXT_IOFS;
	wire rd_is_fptr = s_axi_araddr == SIPR_OFF_FRAME_PTR;
	wire rd_is_short = s_axi_araddr == SIPR_OFF_SHORT_IOFS;
	wire rd_is_mode = s_axi_araddr == SIPR_OFF_MODE;
	wire rd_is_limit = s_axi_araddr == SIPR_OFF_LIMIT;
	wire rd_is_caddr = s_axi_araddr == SIPR_OFF_CODE_ADDR;
	wire rd_is_saddr = s_axi_araddr == SIPR_OFF_STACK_ADDR;
	wire rd_is_cbase = s_axi_araddr == SIPR_OFF_CODE_BASE;
	wire rd_is_sbase = s_axi_araddr == SIPR_OFF_STACK_BASE;
	wire [31:0] rd_word;
	wire rd_ok;

	// anything unmapped or misaligned answers with an error and zero data
	assign rd_ok = rd_is_sel || rd_is_iofs || rd_is_fptr || rd_is_short || rd_is_mode
		|| rd_is_limit || rd_is_caddr || rd_is_saddr || rd_is_cbase || rd_is_sbase;
	// the limit word reads back the limit in force, not the programmed one
	assign rd_word = rd_is_sel ? {16'h0000, sel_reg[rd_sel_idx]} :
		rd_is_iofs ? iofs_reg :
		rd_is_fptr ? fptr_reg :
		rd_is_short ? {16'h0000, iofs_reg[15:0]} :
		rd_is_mode ? {31'h0000_0000, prot_mode_reg} :
		rd_is_limit ? lim.limit :
		rd_is_caddr ? fetch_addr_out :
		rd_is_saddr ? frame_addr_out :
		rd_is_cbase ? code_base_in :
		rd_is_sbase ? stack_base_in : 32'h0000_0000;

	// ----------------------------------------
	// read channel handshake
	// ----------------------------------------
	assign s_axi_arready = !rvalid_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;

	// read answer flag: set by a taken address, cleared once the master takes the data
	always_ff @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
			rvalid_reg <= 1'b0;
		else if (rd_fire)
			rvalid_reg <= 1'b1;
		else if (s_axi_rready)
			rvalid_reg <= 1'b0;
	end

	// read payload, captured with the address so it stands while rvalid is high
	always_ff @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= SIPR_RESP_OKAY;
		end
		else if (rd_fire)
		begin
			rdata_reg <= rd_word;
			rresp_reg <= rd_ok ? SIPR_RESP_OKAY : SIPR_RESP_SLVERR;
		end
	end
endmodule // sipr_top
`default_nettype wire

// ### dv/sipr_sva.sv
`default_nettype none
module sipr_sva
	import sipr_pkg::*;
(
	// clock and reset
	input wire logic clk_in,
	input wire logic resetn_in,
	// core side
	input wire sipr_pkg::sipr_core_wr_t core_wr_in,
	input wire logic [31:0] code_base_in,
	input wire logic [31:0] stack_base_in,
	// views
	input wire logic [SIPR_NUM_SEL*SIPR_SEL_W-1:0] selectors_out,
	input wire logic [31:0] next_instruction_offset_out,
	input wire logic [15:0] short_instruction_offset_out,
	input wire logic [31:0] stack_frame_pointer_out,
	input wire logic [31:0] fetch_addr_out,
	input wire logic [31:0] frame_addr_out,
	input wire sipr_pkg::sipr_limit_t seg_limit_out,
	input wire logic iofs_over_limit_out,
	// bus answers
	input wire logic s_axi_bvalid,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!resetn_in);
	// registers are undefined until the core writes them, so checks wait for that
	logic ip_seen_reg;
	logic fp_seen_reg;
	always_ff @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
			{ip_seen_reg, fp_seen_reg} <= 2'b00;
		else
			{ip_seen_reg, fp_seen_reg} <= {ip_seen_reg | (core_wr_in.iofs_we & ~core_wr_in.iofs_short),
				fp_seen_reg | core_wr_in.fptr_we};
	end
	// ----------------------------------------
	// properties
	// ----------------------------------------
	sequence s_full_ip;
		core_wr_in.iofs_we && !core_wr_in.iofs_short;
	endsequence
	sequence s_short_ip;
		ip_seen_reg && core_wr_in.iofs_we && core_wr_in.iofs_short;
	endsequence
	property p_ip_wr;
		s_full_ip |=> next_instruction_offset_out == $past(core_wr_in.iofs_data);
	endproperty
	property p_fetch;
		ip_seen_reg |-> fetch_addr_out == code_base_in + next_instruction_offset_out;
	endproperty
	property p_short;
		ip_seen_reg |-> short_instruction_offset_out == next_instruction_offset_out[15:0];
	endproperty
	property p_short_wr;
		s_short_ip |=> next_instruction_offset_out[15:0] == $past(core_wr_in.iofs_data[15:0])
			&& next_instruction_offset_out[31:16] == $past(next_instruction_offset_out[31:16]);
	endproperty
	property p_sel_wr;
		core_wr_in.sel_we && core_wr_in.sel_idx < 3'h6 |=> 16'(selectors_out
			>> {$past(core_wr_in.sel_idx), 4'h0}) == $past(core_wr_in.sel_data);
	endproperty
	property p_fp;
		core_wr_in.fptr_we |=> stack_frame_pointer_out == $past(core_wr_in.fptr_data)
			##0 frame_addr_out == stack_base_in + stack_frame_pointer_out;
	endproperty
	property p_fp_hold;
		fp_seen_reg && !core_wr_in.fptr_we |=> $stable(stack_frame_pointer_out) || $rose(s_axi_bvalid);
	endproperty
	property p_real;
		!seg_limit_out.prot_mode |-> seg_limit_out.limit == SIPR_REAL_LIMIT
			&& (!ip_seen_reg || !iofs_over_limit_out);
	endproperty
	property p_prot;
		seg_limit_out.prot_mode && ip_seen_reg |->
			iofs_over_limit_out == (next_instruction_offset_out > seg_limit_out.limit);
	endproperty
	property p_rd_done;
		s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
	endproperty
	a_ip_wr: assert property (p_ip_wr) else $error("offset write lost");
	a_fetch: assert property (p_fetch) else $error("fetch address wrong");
	a_short: assert property (p_short) else $error("short offset wrong");
	a_short_wr: assert property (p_short_wr) else $error("short write wrong");
	a_sel_wr: assert property (p_sel_wr) else $error("selector write lost");
	a_fp: assert property (p_fp) else $error("frame pointer wrong");
	a_fp_hold: assert property (p_fp_hold) else $error("frame pointer drifted");
	a_real: assert property (p_real) else $error("real mode limit wrong");
	a_prot: assert property (p_prot) else $error("protected limit wrong");
	a_rd_done: assert property (p_rd_done) else $error("read answer stuck");
endmodule // sipr_sva
bind sipr_top sipr_sva chk_u (.clk_in(clk_in), .resetn_in(resetn_in), .core_wr_in(core_wr_in),
	.code_base_in(code_base_in), .stack_base_in(stack_base_in), .selectors_out(selectors_out),
	.next_instruction_offset_out(next_instruction_offset_out),
	.short_instruction_offset_out(short_instruction_offset_out),
	.stack_frame_pointer_out(stack_frame_pointer_out), .fetch_addr_out(fetch_addr_out),
	.frame_addr_out(frame_addr_out), .seg_limit_out(seg_limit_out),
	.iofs_over_limit_out(iofs_over_limit_out), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
`default_nettype wire

// ### dv/tb.sv
`default_nettype none
module tb
	import sipr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_in, resetn_in, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid, over;
	logic [7:0] awaddr, araddr;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, rs;
	logic [31:0] cbase, sbase, seed, rd, v, w, wdata, rdata, nio, sfp, faddr, fraddr;
	logic [15:0] sio;
	logic [95:0] sels;
	sipr_core_wr_t cw;
	sipr_limit_t lim;
	int errors, n_compared;
	sipr_top dut_u (.clk_in(clk_in), .resetn_in(resetn_in), .core_wr_in(cw), .code_base_in(cbase),
		.stack_base_in(sbase), .selectors_out(sels), .next_instruction_offset_out(nio),
		.short_instruction_offset_out(sio), .stack_frame_pointer_out(sfp), .fetch_addr_out(faddr),
		.frame_addr_out(fraddr), .seg_limit_out(lim), .iofs_over_limit_out(over),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e)
		begin
			errors++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic complete_run();
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	function automatic logic [31:0] r32();
		seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h0040_0007 : 32'h0000_0000);
		return seed;
	endfunction
	// protected mode flags an offset past the limit, real mode never does
	function automatic logic exp_over(input logic p, input logic [31:0] o, input logic [31:0] l);
		return p && (o > l);
	endfunction
	// write: address and data offered together, each dropped once taken
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge clk_in);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		{awvalid, wvalid, bready} <= 3'b111;
		do
		begin
			@(posedge clk_in);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end
		while ((awvalid && !awready) || (wvalid && !wready));
		while (bvalid !== 1'b1)
			@(posedge clk_in);
		rs = bresp;
		bready <= 1'b0;
	endtask
	task automatic axr(input logic [7:0] a);
		@(posedge clk_in);
		araddr <= a;
		{arvalid, rready} <= 2'b11;
		do
			@(posedge clk_in);
		while (arready !== 1'b1);
		arvalid <= 1'b0;
		do
			@(posedge clk_in);
		while (rvalid !== 1'b1);
		rd = rdata;
		rs = rresp;
		rready <= 1'b0;
	endtask
	// core write lasts one edge; ports are sampled at the following falling edge
	task automatic cwr(input sipr_core_wr_t c);
		@(posedge clk_in);
		cw <= c;
		@(posedge clk_in);
		cw <= '0;
		@(negedge clk_in);
	endtask
	task automatic cip(input logic [31:0] o);
		cwr('{iofs_we: 1'b1, iofs_data: o, default: '0});
	endtask
	// ----------------------------------------
	// clock, watchdog, tests
	// ----------------------------------------
	initial
	begin
		clk_in = 1'b0;
		forever
			#50 clk_in = ~clk_in;
	end
	initial
	begin
		#(30000 * 100);
		errors++;
		complete_run();
	end
	initial
	begin
		errors = 0;
		n_compared = 0;
		seed = 32'h3693_5e0d;
		{resetn_in, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata, wstrb, cw} = '0;
		cbase = r32();
		sbase = r32();
		repeat (16) @(posedge clk_in);
		resetn_in <= 1'b1;
		for (int i = 0; i < SIPR_NUM_SEL; i++)
		begin
			v = r32();
			axw(8'(i * 4), v, 4'hF);
			axr(8'(i * 4));
			chk("sel bus", {16'h0000, v[15:0]}, rd);
			cwr('{sel_we: 1'b1, sel_idx: 3'(i), sel_data: v[31:16], default: '0});
			chk("sel port", {16'h0000, v[31:16]}, {16'h0000, sels[i * 16 +: 16]});
		end
		$display("test selectors done");
		v = r32();
		w = r32();
		axw(SIPR_OFF_NEXT_IOFS, v, 4'hF);
		axr(SIPR_OFF_SHORT_IOFS);
		chk("short bus", {16'h0000, v[15:0]}, rd);
		axr(SIPR_OFF_CODE_ADDR);
		chk("fetch bus", cbase + v, rd);
		axw(SIPR_OFF_NEXT_IOFS, w, 4'h3);
		axr(SIPR_OFF_NEXT_IOFS);
		chk("offset merge", {v[31:16], w[15:0]}, rd);
		cwr('{iofs_we: 1'b1, iofs_short: 1'b1, iofs_data: ~w, default: '0});
		chk("short core", {v[31:16], ~w[15:0]}, nio);
		chk("short port", {16'h0000, ~w[15:0]}, 32'(sio));
		chk("fetch port", cbase + {v[31:16], ~w[15:0]}, faddr);
		$display("test offset done");
		repeat (8)
		begin
			v = r32();
			cwr('{fptr_we: 1'b1, fptr_data: v, default: '0});
			chk("frame addr", sbase + v, fraddr);
			axr(SIPR_OFF_FRAME_PTR);
			chk("frame bus", v, rd);
			cwr('{sel_we: 1'b1, sel_idx: SIPR_SEL_STACK, sel_data: w[15:0], default: '0});
			repeat (3) @(posedge clk_in);
			chk("frame hold", v, sfp);
		end
		$display("test frame done");
		axr(SIPR_OFF_MODE);
		chk("mode reset", 32'h0000_0000, rd);
		axr(SIPR_OFF_LIMIT);
		chk("real limit", SIPR_REAL_LIMIT, rd);
		cip(32'hFFFF_FFFF);
		chk("real over", 32'(exp_over(1'b0, 32'hFFFF_FFFF, SIPR_REAL_LIMIT)), 32'(over));
		axw(SIPR_OFF_MODE, 32'h0000_0001, 4'hF);
		axw(SIPR_OFF_LIMIT, 32'h0000_0000, 4'hF);
		for (int k = 0; k < 2; k++)
		begin
			cip(32'(k));
			chk("byte seg", 32'(exp_over(1'b1, 32'(k), 32'h0000_0000)), 32'(over));
		end
		axw(SIPR_OFF_LIMIT, SIPR_PROT_LIMIT_MAX, 4'hF);
		chk("full seg", 32'(exp_over(1'b1, 32'h0000_0001, SIPR_PROT_LIMIT_MAX)), 32'(over));
		chk("limit view", SIPR_PROT_LIMIT_MAX, lim.limit);
		axw(SIPR_OFF_MODE, 32'h0000_0000, 4'hF);
		axr(SIPR_OFF_LIMIT);
		chk("limit back", SIPR_REAL_LIMIT, rd);
		$display("test limits done");
		axr(8'h3C);
		chk("unmapped rd", 32'h0000_0000, rd);
		chk("unmapped rresp", 32'(SIPR_RESP_SLVERR), 32'(rs));
		axr(8'h02);
		chk("misaligned rresp", 32'(SIPR_RESP_SLVERR), 32'(rs));
		axw(8'h3C, r32(), 4'hF);
		chk("unmapped wr", 32'(SIPR_RESP_SLVERR), 32'(rs));
		v = r32();
		axw(SIPR_OFF_SHORT_IOFS, v, 4'hF);
		axr(SIPR_OFF_NEXT_IOFS);
		chk("short bus wr", {16'h0000, v[15:0]}, rd);
		axw(SIPR_OFF_FRAME_PTR, v, 4'hF);
		axr(SIPR_OFF_STACK_ADDR);
		chk("frame addr bus", sbase + v, rd);
		axw(SIPR_OFF_CODE_BASE, ~cbase, 4'hF);
		chk("ro wr resp", 32'(SIPR_RESP_OKAY), 32'(rs));
		axr(SIPR_OFF_CODE_BASE);
		chk("ro kept", cbase, rd);
		$display("test unmapped done");
		complete_run();
	end
endmodule // tb
`default_nettype wire
